//--- logic/spi_fram_pkg.sv
// constants, state encoding and widths for the serial memory port
// assumes a single 200 MHz system clock with the serial lines sampled through two flops
package spi_fram_pkg;

    // ****************************************
    // array geometry
    // ****************************************
    localparam int          BYTE_W       = 8;
    localparam int          ADDR_W       = 13;
    localparam int          MEM_DEPTH    = 8192;
    localparam int          WIRE_ADDR_W  = 16;
    localparam int          WR_FIFO_DEPTH = 8;

    // ****************************************
    // serial clock limits
    // ****************************************
    localparam int          SYS_CLK_MHZ  = 200;
    localparam int          SCK_MAX_MHZ  = 20;
    localparam int          SCK_MIN_SYS_CYCLES = SYS_CLK_MHZ / SCK_MAX_MHZ;

    // ****************************************
    // command codes
    // ****************************************
    localparam logic [7:0]  OP_SET_WRITE_LATCH   = 8'h06;
    localparam logic [7:0]  OP_CLEAR_WRITE_LATCH = 8'h04;
    localparam logic [7:0]  OP_STATUS_READ       = 8'h05;
    localparam logic [7:0]  OP_STATUS_WRITE      = 8'h01;
    localparam logic [7:0]  OP_MEM_READ          = 8'h03;
    localparam logic [7:0]  OP_MEM_WRITE         = 8'h02;

    // ****************************************
    // status byte layout
    // ****************************************
    localparam int          STATUS_WEL_BIT  = 1;
    localparam logic [7:0]  STATUS_WR_MASK  = 8'hfc;
    localparam logic [7:0]  STATUS_RESET    = 8'h00;
    localparam logic [2:0]  LAST_BIT        = 3'h7;
    localparam logic [2:0]  FIRST_BIT       = 3'h0;
    localparam logic [1:0]  SYNC_HIGH       = 2'h3;

    // ****************************************
    // transaction phases, gray along the memory read path
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_CMD  = 3'h1,
        ST_ADDR = 3'h3,
        ST_DOUT = 3'h2,
        ST_DIN  = 3'h6,
        ST_SKIP = 3'h7
    } spi_state_t;

endpackage

//--- logic/byte_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
module byte_fifo
    import spi_fram_pkg::*;
#(
    parameter int WIDTH = 21,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PTR_W = $clog2(DEPTH);

    typedef struct packed {
        logic [PTR_W-1:0] rd_ptr;
        logic [PTR_W-1:0] wr_ptr;
        logic [PTR_W:0]   count;
    } fifo_t;

    fifo_t            r;
    fifo_t            next_r;
    logic [WIDTH-1:0] store [DEPTH];
    logic             push;
    logic             pop;

    assign in_ready  = (r.count != (PTR_W+1)'(DEPTH));
    assign out_valid = (r.count != '0);
    assign out_data  = store[r.rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_r = r;
        if (push) begin
            next_r.wr_ptr = (r.wr_ptr == PTR_W'(DEPTH-1)) ? '0 : r.wr_ptr + PTR_W'(1);
        end
        if (pop) begin
            next_r.rd_ptr = (r.rd_ptr == PTR_W'(DEPTH-1)) ? '0 : r.rd_ptr + PTR_W'(1);
        end
        case ({push, pop})
            2'h2:    next_r.count = r.count + (PTR_W+1)'(1);
            2'h1:    next_r.count = r.count - (PTR_W+1)'(1);
            default: next_r.count = r.count;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
        if (push) begin
            store[r.wr_ptr] <= in_data;
        end
    end

endmodule // byte_fifo

//--- logic/serial_fram_spi_port.sv
// serial memory port: shifter, command decoder, status and 8k x 8 array
// assumes serial pins are asynchronous to sys_clk and sampled through two flops
module serial_fram_spi_port
    import spi_fram_pkg::*;
#(
    parameter int FIFO_DEPTH = WR_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // serial pins
    input  wire logic select_n,
    input  wire logic serial_clk,
    input  wire logic serial_in,
    input  wire logic pause_n,
    input  wire logic status_write_guard_n,
    // serial output as two signals
    output logic      serial_out,
    output logic      serial_out_oe,
    // power state
    output logic      standby
);
    localparam int WORD_W = ADDR_W + BYTE_W;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [1:0]              cs_sync;
        logic [1:0]              sclk_sync;
        logic [1:0]              mosi_sync;
        logic [1:0]              pause_sync;
        logic [1:0]              guard_sync;
        logic                    sclk_prev;
        spi_state_t              state;
        logic [2:0]              bit_cnt;
        logic [BYTE_W-1:0]       shift_in;
        logic [BYTE_W-1:0]       opcode;
        logic                    addr_lo;
        logic [WIRE_ADDR_W-1:0]  addr;
        logic [BYTE_W-1:0]       tx;
        logic [BYTE_W-1:0]       status;
        logic                    write_enable_flag;
        logic                    wrote;
        logic                    drive;
        logic                    pend;
        logic [WORD_W-1:0]       pend_word;
        logic                    miso;
        logic                    miso_oe;
        logic                    standby;
    } core_t;

    localparam core_t CORE_RESET = '{
        cs_sync:    SYNC_HIGH,
        pause_sync: SYNC_HIGH,
        guard_sync: SYNC_HIGH,
        state:      ST_IDLE,
        status:     STATUS_RESET,
        standby:    1'b1,
        default:    '0
    };

    core_t             r;
    core_t             next_r;
    logic [BYTE_W-1:0] mem [MEM_DEPTH];
    logic [BYTE_W-1:0] rd_data;
    logic              fifo_in_ready;
    logic              fifo_out_valid;
    logic [WORD_W-1:0] fifo_out_data;
    logic              drain_ready;
    logic              rise;
    logic              fall;
    logic              paused;
    logic              cs_high;
    logic              can_shift;
    logic [BYTE_W-1:0] rx_byte;
    logic [BYTE_W-1:0] status_view;
    logic [BYTE_W-1:0] src;

    // ****************************************
    // write buffer between shifter and array
    // ****************************************
    byte_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_write_buffer (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .in_valid  (r.pend),
        .in_ready  (fifo_in_ready),
        .in_data   (r.pend_word),
        .out_valid (fifo_out_valid),
        .out_ready (drain_ready),
        .out_data  (fifo_out_data)
    );

    // single-port array: reads in a data-out phase take the port first
    assign drain_ready = (r.state != ST_DOUT);

    always_ff @(posedge sys_clk) begin
        if (fifo_out_valid && drain_ready) begin
            mem[fifo_out_data[WORD_W-1:BYTE_W]] <= fifo_out_data[BYTE_W-1:0];
        end
        rd_data <= mem[r.addr[ADDR_W-1:0]];
    end

    // ****************************************
    // edge detection and decode
    // ****************************************
    assign rise        = r.sclk_sync[1] && !r.sclk_prev;
    assign fall        = !r.sclk_sync[1] && r.sclk_prev;
    assign paused      = !r.pause_sync[1];
    assign cs_high     = r.cs_sync[1];
    assign can_shift   = !r.pend || fifo_in_ready;
    assign rx_byte     = {r.shift_in[BYTE_W-2:0], r.mosi_sync[1]};
    assign status_view = (r.status & STATUS_WR_MASK)
                       | (BYTE_W'(r.write_enable_flag) << STATUS_WEL_BIT);
    assign src         = (r.bit_cnt != FIRST_BIT) ? r.tx
                       : (r.opcode == OP_STATUS_READ) ? status_view : rd_data;

    always_comb begin
        next_r            = r;
        next_r.cs_sync    = {r.cs_sync[0], select_n};
        next_r.sclk_sync  = {r.sclk_sync[0], serial_clk};
        next_r.mosi_sync  = {r.mosi_sync[0], serial_in};
        next_r.pause_sync = {r.pause_sync[0], pause_n};
        next_r.guard_sync = {r.guard_sync[0], status_write_guard_n};
        next_r.sclk_prev  = r.sclk_sync[1];
        if (r.pend && fifo_in_ready) begin
            next_r.pend = 1'b0;
        end
        if (paused) begin
            // frozen: only the synchronisers, the pending write handoff and the output enable move
            next_r.state = r.state;
        end else if (cs_high) begin
            if (r.wrote) begin
                next_r.write_enable_flag = 1'b0;
            end
            next_r.state   = ST_IDLE;
            next_r.wrote   = 1'b0;
            next_r.drive   = 1'b0;
            next_r.standby = 1'b1;
        end else begin
            next_r.standby = 1'b0;
            if (r.state == ST_IDLE) begin
                // only left with select low after select was high, so each command follows a fresh fall
                next_r.state   = ST_CMD;
                next_r.bit_cnt = FIRST_BIT;
                next_r.addr_lo = 1'b0;
            end else if (rise && can_shift) begin
                next_r.shift_in = rx_byte;
                next_r.bit_cnt  = r.bit_cnt + 3'h1;
                if (r.bit_cnt == LAST_BIT) begin
                    case (r.state)
                        ST_CMD: begin
                            next_r.opcode = rx_byte;
                            case (rx_byte)
                                OP_SET_WRITE_LATCH: begin
                                    next_r.write_enable_flag = 1'b1;
                                    next_r.state             = ST_SKIP;
                                end
                                OP_CLEAR_WRITE_LATCH: begin
                                    next_r.write_enable_flag = 1'b0;
                                    next_r.state             = ST_SKIP;
                                end
                                OP_STATUS_READ:  next_r.state = ST_DOUT;
                                OP_STATUS_WRITE: next_r.state = ST_DIN;
                                OP_MEM_READ:     next_r.state = ST_ADDR;
                                OP_MEM_WRITE:    next_r.state = ST_ADDR;
                                default:         next_r.state = ST_SKIP;
                            endcase
                        end
                        ST_ADDR: begin
                            next_r.addr    = {r.addr[BYTE_W-1:0], rx_byte};
                            next_r.addr_lo = 1'b1;
                            if (r.addr_lo) begin
                                next_r.state = (r.opcode == OP_MEM_READ) ? ST_DOUT : ST_DIN;
                            end
                        end
                        ST_DIN: begin
                            if (r.opcode == OP_STATUS_WRITE) begin
                                if (r.write_enable_flag && r.guard_sync[1]) begin
                                    next_r.status = rx_byte & STATUS_WR_MASK;
                                end
                                next_r.wrote = r.write_enable_flag;
                                next_r.state = ST_SKIP;
                            end else if (r.write_enable_flag) begin
                                next_r.pend      = 1'b1;
                                next_r.pend_word = {r.addr[ADDR_W-1:0], rx_byte};
                                next_r.wrote     = 1'b1;
                                next_r.addr      = r.addr + WIRE_ADDR_W'(1);
                            end
                        end
                        ST_DOUT: begin
                            if (r.opcode == OP_MEM_READ) begin
                                next_r.addr = r.addr + WIRE_ADDR_W'(1);
                            end
                        end
                        default: next_r.state = r.state;
                    endcase
                end
            end else if (fall && r.state == ST_DOUT) begin
                next_r.miso  = src[BYTE_W-1];
                next_r.tx    = src << 1;
                next_r.drive = 1'b1;
            end
        end
        // released while paused or selected off; restored at the frozen bit
        next_r.miso_oe = next_r.drive && (next_r.state == ST_DOUT)
                       && !paused && !(cs_high && !paused);
        if (!paused && !cs_high && r.state != ST_IDLE && r.state != ST_DOUT) begin
            next_r.drive = 1'b0;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            r <= CORE_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign serial_out    = r.miso;
    assign serial_out_oe = r.miso_oe;
    assign standby       = r.standby;

endmodule // serial_fram_spi_port

//--- test/serial_port_checker.sv
// checker: timing of the serial output, select and pause at the top ports
// assumes each serial line level lasts at least 8 sys_clk cycles
module serial_port_checker (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic select_n,
    input wire logic serial_clk,
    input wire logic serial_in,
    input wire logic pause_n,
    input wire logic status_write_guard_n,
    input wire logic serial_out,
    input wire logic serial_out_oe,
    input wire logic standby
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    logic [7:0] rises;
    // rising serial clock edges seen in this frame
    always_ff @(posedge sys_clk) begin
        if (rst || (select_n && pause_n))
            rises <= 8'h00;
        else if (pause_n && $rose(serial_clk) && rises != 8'hff)
            rises <= rises + 8'h01;
    end
    sequence s_sel_idle;
        (select_n && pause_n) [*6];
    endsequence
    sequence s_sel_busy;
        (!select_n && pause_n) [*6];
    endsequence
    sequence s_paused;
        (!pause_n) [*6];
    endsequence
    a_sel_quiet: assert property (s_sel_idle |-> !serial_out_oe)
        else $error("output driven while deselected");
    a_sel_standby: assert property (s_sel_idle |-> standby)
        else $error("standby low while deselected");
    a_sel_active: assert property (s_sel_busy |-> !standby)
        else $error("standby high while selected");
    a_out_on_fall: assert property (serial_out_oe && $past(serial_out_oe) && $changed(serial_out)
        |-> !serial_clk && !$past(serial_clk, 2)) else $error("output moved after rising edge");
    a_oe_cause: assert property ($rose(serial_out_oe)
        |-> !select_n && pause_n && !serial_clk) else $error("output enabled out of a read phase");
    a_rx_silent: assert property (serial_out_oe && !select_n && pause_n |-> rises >= 8'h08)
        else $error("output driven while receiving command");
    a_pause_held: assert property (s_paused |-> !serial_out_oe)
        else $error("output driven while paused");
    a_pause_off: assert property ($fell(pause_n) |-> ##[1:6] !serial_out_oe)
        else $error("output not released on pause");
endmodule // serial_port_checker

bind serial_fram_spi_port serial_port_checker chk_u (.sys_clk(sys_clk), .rst(rst), .select_n(select_n),
    .serial_clk(serial_clk), .serial_in(serial_in), .pause_n(pause_n), .status_write_guard_n(status_write_guard_n),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe), .standby(standby));

//--- test/spi_master_model.sv
// bus master model: frames of whole bytes, mode 0 or 3, optional pause
// assumes sys_clk at 200 MHz; serial clock half period 16 cycles (80 ns)
module spi_master_model (
    // clock
    input  wire logic sys_clk,
    // serial pins
    output logic      select_n,
    output logic      serial_clk,
    output logic      serial_in,
    output logic      pause_n,
    output logic      status_write_guard_n,
    input  wire logic serial_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic mode3 = 1'b0;
    int   pause_at = -1;
    initial begin
        select_n = 1'b1;
        serial_clk = 1'b0;
        serial_in = 1'b0;
        pause_n = 1'b1;
        status_write_guard_n = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // pause with clock low; clock and select wiggle meanwhile
    task automatic hold_pause();
        pause_n <= 1'b0;
        tick(8);
        repeat (2) begin
            serial_clk <= 1'b1;
            select_n <= 1'b1;
            tick(8);
            serial_clk <= 1'b0;
            select_n <= 1'b0;
            tick(8);
        end
        pause_n <= 1'b1;
        tick(8);
    endtask
    // n bytes from tx top down, one command per select fall
    task automatic frame(input int n, input logic [47:0] tx, output logic [47:0] rx);
        rx = '0;
        serial_clk <= mode3;
        tick(8);
        select_n <= 1'b0;
        tick(8);
        for (int i = 0; i < n * 8; i++) begin
            serial_clk <= 1'b0;
            serial_in <= tx[47 - i];
            tick(8);
            if (i == pause_at)
                hold_pause();
            tick(8);
            rx[47 - i] = serial_out;
            serial_clk <= 1'b1;
            tick(16);
        end
        // clock rests at its idle level between frames
        serial_clk <= mode3;
        tick(8);
        select_n <= 1'b1;
        serial_in <= ~serial_in;
        tick(8);
    endtask
endmodule // spi_master_model

//--- test/test_serial_fram_spi_port.sv
// testbench: writes, reads, latch, guard and pause through the master model
// assumes the design package and the master model are compiled first
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module test_serial_fram_spi_port
    import spi_fram_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk;
    logic        rst;
    logic        select_n, serial_clk, serial_in, pause_n, status_write_guard_n;
    logic        serial_out, serial_out_oe, standby;
    logic [47:0] rx;
    int          errors = 0;
    int          checked = 0;
    int          cycles = 0;
    serial_fram_spi_port dut_u (.sys_clk(sys_clk), .rst(rst), .select_n(select_n), .serial_clk(serial_clk),
        .serial_in(serial_in), .pause_n(pause_n), .status_write_guard_n(status_write_guard_n),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe), .standby(standby));
    spi_master_model mst (.sys_clk(sys_clk), .select_n(select_n), .serial_clk(serial_clk),
        .serial_in(serial_in), .pause_n(pause_n), .status_write_guard_n(status_write_guard_n),
        .serial_out(serial_out));
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            test_done();
        end
    end
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] op);
        mst.frame(1, {op, 40'h0}, rx);
    endtask
    task automatic status_is(input logic [7:0] e);
        mst.frame(2, {OP_STATUS_READ, 40'h0}, rx);
        `CHK("status", e, rx[39:32])
    endtask
    task automatic t_reset();
        `CHK("standby", 1'b1, standby)
        `CHK("oe", 1'b0, serial_out_oe)
        status_is(STATUS_RESET);
    endtask
    task automatic t_latch();
        cmd(OP_SET_WRITE_LATCH);
        status_is(8'h02);
        // unknown code: the rest of its frame, a clear code too, is ignored
        mst.frame(2, {8'hff, OP_CLEAR_WRITE_LATCH, 32'h0}, rx);
        status_is(8'h02);
        cmd(OP_CLEAR_WRITE_LATCH);
        status_is(8'h00);
    endtask
    task automatic t_wr_rd();
        cmd(OP_SET_WRITE_LATCH);
        mst.frame(5, {OP_MEM_WRITE, 16'hfffe, 16'ha53c, 8'h00}, rx);
        mst.mode3 = 1'b1;
        mst.frame(5, {OP_MEM_READ, 16'h1ffe, 16'h0000, 8'h00}, rx);
        `CHK("read pair", 16'ha53c, rx[23:8])
        status_is(8'h00);
        mst.mode3 = 1'b0;
    endtask
    task automatic t_nolatch();
        cmd(OP_SET_WRITE_LATCH);
        mst.frame(4, {OP_MEM_WRITE, 16'h0fff, 8'h11, 16'h0}, rx);
        mst.frame(4, {OP_MEM_WRITE, 16'h0fff, 8'h77, 16'h0}, rx);
        mst.frame(4, {OP_MEM_READ, 16'h0fff, 24'h0}, rx);
        `CHK("no latch", 8'h11, rx[23:16])
        mst.frame(4, {OP_MEM_READ, 16'h1fff, 24'h0}, rx);
        `CHK("top cell", 8'h3c, rx[23:16])
    endtask
    task automatic t_guard();
        mst.status_write_guard_n <= 1'b0;
        cmd(OP_SET_WRITE_LATCH);
        mst.frame(2, {OP_STATUS_WRITE, 8'hfc, 32'h0}, rx);
        status_is(8'h00);
        cmd(OP_SET_WRITE_LATCH);
        mst.frame(4, {OP_MEM_WRITE, 16'h0010, 8'h5a, 16'h0}, rx);
        mst.frame(4, {OP_MEM_READ, 16'h0010, 24'h0}, rx);
        `CHK("guarded mem", 8'h5a, rx[23:16])
        mst.status_write_guard_n <= 1'b1;
        cmd(OP_SET_WRITE_LATCH);
        mst.frame(2, {OP_STATUS_WRITE, 8'hfc, 32'h0}, rx);
        status_is(8'hfc);
    endtask
    // pause inside the address, then inside the data byte
    task automatic t_pause();
        mst.pause_at = 12;
        mst.frame(4, {OP_MEM_READ, 16'h0fff, 24'h0}, rx);
        `CHK("pause addr", 8'h11, rx[23:16])
        mst.pause_at = 29;
        mst.frame(4, {OP_MEM_READ, 16'h0010, 24'h0}, rx);
        `CHK("pause data", 8'h5a, rx[23:16])
        mst.pause_at = -1;
    endtask
    initial begin
        rst = 1'b1;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        t_reset();
        t_latch();
        t_wr_rd();
        t_nolatch();
        t_guard();
        t_pause();
        test_done();
    end
endmodule // test_serial_fram_spi_port
